/* File: logic/adc_ctl_defs.svh */
// Offsets, field positions, reset values and timing counts of the control bank
// Operation
// - General source code 01 scan end, 10 half full, 11 not empty, 00 none.
// - Write bit 2 enables the general-source interrupt; the bit 7 flag latches without it.
// - Write bit 4 enables the acquisition-done interrupt.
// - Writing 1 to bit 6 or 7 clears acquisition-done or general status.
// - Writing 1 to bit 13 clears the latched overflow indication.
// - Clear bits act as single pulses; no write-back to zero needed.
// - Read bit 6 reports latched acquisition-done event.
// - Read bit 7 reports latched selected general source.
// - Read bit 9 reports latched burst-done, meaningful only in burst mode.
// - Read bit 10 latches when FIFO holds more than 255 samples.
// - Read bit 11 latches when FIFO becomes non-empty; zero when emptied.
// - Read bit 12 shows live FIFO not-empty.
// - Read bit 13 latches write into full FIFO until cleared.
// - Channel write loads start; advance per conversion, wrap after stop.
// - Start channel in bits 3..0, stop channel in bits 7..4.
// - Range field bits 9..8: 10V, 5V, 2.5V, 1.25V.
// - Bit 10: single-ended 16 channels when 1, differential 8 when 0.
// - Bit 11: unipolar when 1, bipolar when 0.
// - Range codes give front-end gains 1, 2, 4 and 8.
// - Pacer source bits 13..12: software, timer, falling, rising; 330KHz max.
// - With software pacing, word write to data region offset 0 converts.
`ifndef ADC_CTL_DEFS_SVH
`define ADC_CTL_DEFS_SVH

`define OFS_IRQ_STATUS 4'h0
`define OFS_SCAN_CTRL 4'h2
`define OFS_CONV_START 4'h0

`define BIT_GEN_IRQ_EN 2
`define BIT_ACQ_IRQ_EN 4
`define BIT_ACQ_CLR 6
`define BIT_GEN_CLR 7
`define BIT_OVF_CLR 13
`define BIT_ACQ_FLAG 6
`define BIT_GEN_FLAG 7
`define BIT_BURST_FLAG 9
`define BIT_HALF_FLAG 10
`define BIT_HAS_DATA_FLAG 11
`define BIT_HAS_DATA_LIVE 12
`define BIT_OVF_FLAG 13

`define HALF_FULL_LIMIT 10'h0ff
`define PACER_MAX_KHZ 330
`define CLK_MHZ 100
`define PACER_MIN_CYCLES ((`CLK_MHZ * 1000 + `PACER_MAX_KHZ - 1) / `PACER_MAX_KHZ)
`define SCAN_RESET 16'h0000

`endif

/* File: logic/adc_ctl_pkg.sv */
// Types for the converter interrupt and scan control bank
package adc_ctl_pkg;
  typedef enum logic [1:0] {
    src_none = 2'h0,
    src_scan_end = 2'h1,
    src_half_full = 2'h2,
    src_not_empty = 2'h3
  } gen_src_e;
  typedef enum logic [1:0] {
    pace_software = 2'h0,
    pace_timer = 2'h1,
    pace_ext_fall = 2'h2,
    pace_ext_rise = 2'h3
  } pacer_e;
  typedef enum logic [1:0] {
    range_10v = 2'h0,
    range_5v = 2'h1,
    range_2v5 = 2'h2,
    range_1v25 = 2'h3
  } range_e;
  typedef struct packed {
    logic fifo_has_data_live;
    logic fifo_over_half;
    logic fifo_write_when_full;
    logic fifo_cleared;
    logic acquisition_done;
    logic burst_done;
    logic burst_mode;
    logic conversion_done;
  } conv_events_s;
  typedef struct packed {
    logic [3:0] channel;
    range_e range_select;
    logic single_vs_differential;
    logic polarity_select;
    logic [3:0] gain;
    pacer_e pacer_source_select;
  } front_end_s;
  typedef struct packed {
    gen_src_e gen_src;
    logic general_irq_enable;
    logic acq_done_irq_enable;
    logic acq_done_flag;
    logic general_flag;
    logic burst_done_flag;
    logic fifo_half_flag;
    logic fifo_has_data_flag;
    logic fifo_overflow_latched;
    logic [3:0] scan_start_channel;
    logic [3:0] scan_stop_channel;
    logic [3:0] channel;
    range_e range_select;
    logic single_vs_differential;
    logic polarity_select;
    pacer_e pacer_source_select;
    logic [15:0] rdata;
    logic sw_convert;
  } state_s;
endpackage : adc_ctl_pkg

/* File: logic/adc_irq_and_scan_control.sv */
// Interrupt, FIFO status and scan control registers of the converter board
`timescale 1ns/1ps
`include "adc_ctl_defs.svh"
module adc_irq_and_scan_control (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_ctl_sel,
  input wire logic i_data_sel,
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_wdata,
  input wire adc_ctl_pkg::conv_events_s i_events,
  output logic [15:0] o_rdata,
  output logic o_irq,
  output logic o_sw_convert,
  output adc_ctl_pkg::front_end_s o_front_end
);
  import adc_ctl_pkg::*;

  state_s q;
  state_s d;
  logic gen_fire;
  logic wr_irq;
  logic wr_scan;

  // Gain doubles with each range step
  function automatic logic [3:0] gain_of(input range_e r);
    gain_of = 4'h1 << r;
  endfunction : gain_of

  always_comb begin
    wr_irq = i_ctl_sel && i_wr && (i_addr == `OFS_IRQ_STATUS);
    wr_scan = i_ctl_sel && i_wr && (i_addr == `OFS_SCAN_CTRL);
    case (q.gen_src)
      src_scan_end: gen_fire = i_events.conversion_done &&
        (q.channel == q.scan_stop_channel);
      src_half_full: gen_fire = i_events.fifo_over_half;
      src_not_empty: gen_fire = i_events.fifo_has_data_live;
      default: gen_fire = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    d.sw_convert = 1'b0;
    if (wr_irq) begin
      d.gen_src = gen_src_e'(i_wdata[1:0]);
      d.general_irq_enable = i_wdata[`BIT_GEN_IRQ_EN];
      d.acq_done_irq_enable = i_wdata[`BIT_ACQ_IRQ_EN];
      // Clears are taken from the write itself, nothing is stored: one pulse
      if (i_wdata[`BIT_ACQ_CLR]) begin
        d.acq_done_flag = 1'b0;
      end
      if (i_wdata[`BIT_GEN_CLR]) begin
        d.general_flag = 1'b0;
      end
      if (i_wdata[`BIT_OVF_CLR]) begin
        d.fifo_overflow_latched = 1'b0;
      end
    end
    // Sets follow clears so an event in the clear cycle is kept
    if (i_events.acquisition_done) begin
      d.acq_done_flag = 1'b1;
    end
    if (gen_fire) begin
      d.general_flag = 1'b1;
    end
    if (i_events.fifo_cleared) begin
      d.burst_done_flag = 1'b0;
      d.fifo_half_flag = 1'b0;
    end
    // Set wins over a FIFO clear in the same cycle
    if (i_events.burst_done && i_events.burst_mode) begin
      d.burst_done_flag = 1'b1;
    end
    if (i_events.fifo_over_half) begin
      d.fifo_half_flag = 1'b1;
    end
    // Not-empty latch drops once the FIFO is cleared or drained
    if (i_events.fifo_cleared || !i_events.fifo_has_data_live) begin
      d.fifo_has_data_flag = 1'b0;
    end else begin
      d.fifo_has_data_flag = 1'b1;
    end
    if (i_events.fifo_write_when_full) begin
      d.fifo_overflow_latched = 1'b1;
    end
    if (wr_scan) begin
      d.scan_start_channel = i_wdata[3:0];
      d.scan_stop_channel = i_wdata[7:4];
      d.channel = i_wdata[3:0];
      d.range_select = range_e'(i_wdata[9:8]);
      d.single_vs_differential = i_wdata[10];
      d.polarity_select = i_wdata[11];
      d.pacer_source_select = pacer_e'(i_wdata[13:12]);
    end else if (i_events.conversion_done) begin
      if (q.channel == q.scan_stop_channel) begin
        d.channel = q.scan_start_channel;
      end else begin
        d.channel = q.channel + 4'h1;
      end
    end
    // Data is ignored; only the word write to offset zero under software pacing matters
    if (i_data_sel && i_wr && (i_addr == `OFS_CONV_START) &&
        (q.pacer_source_select == pace_software)) begin
      d.sw_convert = 1'b1;
    end
    d.rdata = 16'h0000;
    if (i_ctl_sel && i_rd && (i_addr == `OFS_IRQ_STATUS)) begin
      d.rdata[`BIT_ACQ_FLAG] = q.acq_done_flag;
      d.rdata[`BIT_GEN_FLAG] = q.general_flag;
      d.rdata[`BIT_BURST_FLAG] = q.burst_done_flag;
      d.rdata[`BIT_HALF_FLAG] = q.fifo_half_flag;
      d.rdata[`BIT_HAS_DATA_FLAG] = q.fifo_has_data_flag;
      d.rdata[`BIT_HAS_DATA_LIVE] = i_events.fifo_has_data_live;
      d.rdata[`BIT_OVF_FLAG] = q.fifo_overflow_latched;
    end else if (i_ctl_sel && i_rd && (i_addr == `OFS_SCAN_CTRL)) begin
      d.rdata = {2'h0, q.pacer_source_select, q.polarity_select,
        q.single_vs_differential, q.range_select, q.scan_stop_channel,
        q.scan_start_channel};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_sw_convert = q.sw_convert;
  assign o_irq = (q.general_flag && q.general_irq_enable) ||
    (q.acq_done_flag && q.acq_done_irq_enable);
  assign o_front_end = '{channel: q.channel,
    range_select: q.range_select,
    single_vs_differential: q.single_vs_differential,
    polarity_select: q.polarity_select,
    gain: gain_of(q.range_select),
    pacer_source_select: q.pacer_source_select};
endmodule : adc_irq_and_scan_control

/* File: tb/adc_irq_scan_props.sv */
// Assertion checker for the converter interrupt and scan control bank
`timescale 1ns/1ps
module adc_irq_scan_props (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_ctl_sel,
  input wire logic i_data_sel,
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_wdata,
  input wire adc_ctl_pkg::conv_events_s i_events,
  input wire logic [15:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_sw_convert,
  input wire adc_ctl_pkg::front_end_s o_front_end
);
  import adc_ctl_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  wire w0 = i_ctl_sel && i_wr && i_addr == 4'h0;
  wire w2 = i_ctl_sel && i_wr && i_addr == 4'h2;
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 16'h0; endproperty
  property p_conv; i_data_sel && i_wr && i_addr == 4'h0 &&
    o_front_end.pacer_source_select == pace_software |=> o_sw_convert;
  endproperty
  // Other pacer sources must never leak a software start
  property p_conv_src; o_sw_convert |-> $past(i_data_sel) && $past(i_wr) &&
    $past(o_front_end.pacer_source_select) == pace_software;
  endproperty
  property p_clear; w0 && i_wdata[7:6] == 2'h3 && i_wdata[1:0] != 2'h3 &&
    i_events == '0 |=> !o_irq;
  endproperty
  property p_irq_off; w0 && !i_wdata[4] && !i_wdata[2] |=> !o_irq; endproperty
  sequence s_acq_en; w0 && i_wdata[4] && !i_wdata[6]; endsequence
  property p_acq_irq; s_acq_en ##1 !w0 ##1 i_events.acquisition_done && !w0
    |=> o_irq;
  endproperty
  property p_scan; w2 |=> o_front_end.channel == $past(i_wdata[3:0]) &&
    {o_front_end.pacer_source_select, o_front_end.polarity_select,
    o_front_end.single_vs_differential, o_front_end.range_select} ==
    $past(i_wdata[13:8]);
  endproperty
  property p_gain; o_front_end.gain == (o_front_end.range_select == range_10v ?
    4'h1 : o_front_end.range_select == range_5v ? 4'h2 :
    o_front_end.range_select == range_2v5 ? 4'h4 : 4'h8);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_conv: assert property (p_conv) else $error("no conversion start");
  a_conv_src: assert property (p_conv_src) else $error("stray start");
  a_clear: assert property (p_clear) else $error("clear failed");
  a_irq_off: assert property (p_irq_off) else $error("irq enabled");
  a_acq_irq: assert property (p_acq_irq) else $error("no acq irq");
  a_scan: assert property (p_scan) else $error("scan load wrong");
  a_gain: assert property (p_gain) else $error("gain decode wrong");
  c_conv: cover property (o_sw_convert);
  c_irq: cover property (o_irq);
  c_scan: cover property (w2);
endmodule : adc_irq_scan_props
bind adc_irq_and_scan_control adc_irq_scan_props adc_irq_scan_props_i (
  .i_core_clk, .i_reset_n, .i_ctl_sel, .i_data_sel, .i_addr, .i_wr, .i_rd,
  .i_wdata, .i_events, .o_rdata, .o_irq, .o_sw_convert, .o_front_end);

/* File: tb/adc_irq_and_scan_control_tb.sv */
// Self-checking bench for the converter interrupt and scan control bank
`timescale 1ns/1ps
module adc_irq_and_scan_control_tb;
  import adc_ctl_pkg::*;
  logic clk = 0, rst_n = 0, cs = 0, ds = 0, wr = 0, rd = 0, irq, swc;
  logic [3:0] a = 4'h0;
  logic [15:0] wd = 16'h0, rdat, v;
  conv_events_s ev = '0;
  front_end_s fe;
  int fail_count = 0, checked = 0, cyc = 0;
  adc_irq_and_scan_control adc_irq_and_scan_control_i (.i_core_clk(clk),
    .i_reset_n(rst_n), .i_ctl_sel(cs), .i_data_sel(ds), .i_addr(a),
    .i_wr(wr), .i_rd(rd), .i_wdata(wd), .i_events(ev), .o_rdata(rdat),
    .o_irq(irq), .o_sw_convert(swc), .o_front_end(fe));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // One word access; strobes held across exactly one rising edge
  task automatic acc(input logic d, w, input logic [3:0] ad,
    input logic [15:0] x);
    @(negedge clk);
    {cs, ds, wr, rd, a, wd} = {!d, d, w, !w, ad, x};
    @(negedge clk);
    {cs, ds, wr, rd} = 4'h0;
    v = rdat;
  endtask : acc
  task automatic pulse(input conv_events_s e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = '0;
  endtask : pulse
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    acc(0, 0, 4'h2, 0);
    chk(v, 16'h0);
    chk(fe.gain, 4'h1);
    acc(0, 1, 4'h2, 16'h3a52);
    chk(fe.channel, 4'h2);
    acc(0, 0, 4'h2, 0);
    chk(v, 16'h3a52);
    chk(fe.range_select, 2'h2);
    chk(fe.gain, 4'h4);
    chk({fe.polarity_select, fe.single_vs_differential}, 2'h2);
    chk(fe.pacer_source_select, 2'h3);
    for (int i = 3; i < 7; i++) begin
      pulse(8'h01);
      chk(fe.channel, i == 6 ? 2 : i);
    end
    acc(1, 1, 4'h0, 16'hffff);
    chk(swc, 0);
    acc(0, 1, 4'h6, 16'hffff);
    acc(0, 0, 4'h6, 0);
    chk(v, 16'h0);
    acc(0, 0, 4'h2, 0);
    chk(v, 16'h3a52);
    acc(0, 1, 4'h2, 16'h0000);
    acc(1, 1, 4'h0, 16'h1234);
    chk(swc, 1);
    @(negedge clk);
    chk(swc, 0);
    $display("scan and convert test done");
    acc(0, 1, 4'h0, 16'h0010);
    pulse(8'h08);
    chk(irq, 1);
    acc(0, 0, 4'h0, 0);
    chk(v, 16'h0040);
    acc(0, 1, 4'h0, 16'h0010);
    chk(irq, 1);
    acc(0, 1, 4'h0, 16'h0050);
    chk(irq, 0);
    acc(0, 1, 4'h0, 16'h0000);
    pulse(8'h08);
    chk(irq, 0);
    acc(0, 0, 4'h0, 0);
    chk(v[6], 1);
    $display("acquisition test done");
    // Code 0 gets every general cause at once yet must not latch the general flag
    for (int s = 0; s < 4; s++) begin
      acc(0, 1, 4'h0, 16'h00c4 | s);
      pulse(s == 0 ? 8'hc1 : s == 1 ? 8'h01 : s == 2 ? 8'h40 : 8'h80);
      @(negedge clk);
      chk(irq, s != 0);
      acc(0, 0, 4'h0, 0);
      chk(v[7], s != 0);
    end
    acc(0, 1, 4'h0, 16'h0083);
    pulse(8'h80);
    @(negedge clk);
    chk(irq, 0);
    ev = 8'h80;
    acc(0, 0, 4'h0, 0);
    chk(v[12:7], 6'h39);
    ev = '0;
    pulse(8'h10);
    acc(0, 0, 4'h0, 0);
    chk(v[12:10], 3'h0);
    $display("general source test done");
    pulse(8'h20);
    acc(0, 0, 4'h0, 0);
    chk(v[13], 1);
    acc(0, 1, 4'h0, 16'h0000);
    acc(0, 0, 4'h0, 0);
    chk(v[13], 1);
    acc(0, 1, 4'h0, 16'h2000);
    acc(0, 0, 4'h0, 0);
    chk(v[13], 0);
    pulse(8'h20);
    acc(0, 0, 4'h0, 0);
    chk(v[13], 1);
    pulse(8'h04);
    acc(0, 0, 4'h0, 0);
    chk(v[9], 0);
    pulse(8'h06);
    acc(0, 0, 4'h0, 0);
    chk(v[9], 1);
    pulse(8'h16);
    acc(0, 0, 4'h0, 0);
    chk(v[9], 1);
    $display("overflow and burst test done");
    end_sim();
  end
endmodule : adc_irq_and_scan_control_tb
